/* tce_top.sv */
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
// ==========================================================
// timer with channel event flags, avalon-mm slave
module tce_top #(
  parameter int NCH = 2                     // channel count
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        background_debug_mode,
  input  wire logic [NCH-1:0] ch_pin,
  output logic             irq
);
  // ==========================================================
  // elaboration check
  if (NCH < 1 || NCH > 4) begin : g_bad
    $error("NCH must be 1 to 4");
  end
  // ==========================================================
  // registers
  logic [2:0]  ps_q;                       // prescale select
  logic        center_pwm_select_q;
  logic        overflow_irq_enable_q;
  logic [15:0] mod_q;                      // modulus
  logic [15:0] cnt_q;                      // main counter
  logic [15:0] cnt_d;
  logic        down_q;                     // counting down in center mode
  logic        down_d;
  logic [NCH:0] flag_q;                    // bit 0 overflow, bit n+1 channel n
  logic [NCH:0] flag_d;
  logic [NCH:0] armed_q;                   // flag was read while set
  logic [NCH:0] armed_d;
  logic [NCH:0] sts_q;                     // sticky status
  logic [NCH:0] mask_q;                    // interrupt mask
  logic [1:0]  ch_mode_q [NCH];
  logic [1:0]  ch_els_q  [NCH];
  logic        ch_ie_q   [NCH];
  logic [15:0] ch_val_q  [NCH];
  logic        ack_q;                      // answer cycle
  logic [31:0] rdata_q;
  // ==========================================================
  // bus decode
  logic        req;
  logic        wr_acc;
  logic        rd_acc;
  logic        cnt_wr;
  logic        flags_wr;
  logic        flags_rd;
  logic [31:0] rd_mux;
  logic [NCH:0] evt;                       // raw events
  logic [NCH:0] irq_en;
  logic        tick;
  assign req    = (avs_read || avs_write) && !ack_q;
  assign wr_acc = avs_write && ack_q;      // write takes effect on answer edge
  assign rd_acc = avs_read && ack_q;
  // one wait cycle per access
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign cnt_wr   = wr_acc && (avs_address == tce_pkg::ADDR_CNT_HI ||
                               avs_address == tce_pkg::ADDR_CNT_LO); // RQ8
  assign flags_wr = wr_acc && (avs_address == tce_pkg::ADDR_FLAGS);
  assign flags_rd = rd_acc && (avs_address == tce_pkg::ADDR_FLAGS);
  // channel register decode shared by read and write paths
  // compared as int so that four channels do not wrap past the 6-bit address top
  function automatic int ch_index(input logic [5:0] a);
    if (int'(a) >= int'(tce_pkg::ADDR_CH_BASE) && int'(a) < int'(tce_pkg::ADDR_CH_BASE) + NCH * 8)
      return int'(a - tce_pkg::ADDR_CH_BASE) >> 3;
    return -1;
  endfunction
  // ==========================================================
  // prescaler
  tce_prescaler u_ps (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (cnt_wr),                    // RQ8
    .freeze   (background_debug_mode),
    .sel      (ps_q),
    .tick     (tick)
  );
  // ==========================================================
  // counter: up with wrap, or up/down in center mode
  logic at_top;
  logic [15:0] top;
  logic        ovf_evt;                    // overflow event, own driver apart from channel events
  assign evt[0] = ovf_evt;
  assign top    = (mod_q == 16'h0000) ? 16'hFFFF : mod_q;
  assign at_top = (cnt_q == top);
  always_comb begin
    cnt_d  = cnt_q;
    down_d = down_q;
    ovf_evt = 1'b0;
    if (cnt_wr) begin
      cnt_d  = 16'h0000;                   // RQ8
      down_d = 1'b0;
    end else if (tick) begin               // RQ14
      if (!center_pwm_select_q) begin
        down_d = 1'b0;
        if (at_top) begin
          cnt_d  = 16'h0000;
          ovf_evt = 1'b1;                  // RQ11
        end else begin
          cnt_d = 16'(cnt_q + 16'h0001);
        end
      end else if (!down_q) begin
        if (at_top) begin
          down_d = 1'b1;
          cnt_d  = 16'(cnt_q - 16'h0001);
          ovf_evt = 1'b1;                  // RQ1
        end else begin
          cnt_d = 16'(cnt_q + 16'h0001);
        end
      end else if (cnt_q == 16'h0000) begin
        down_d = 1'b0;
        cnt_d  = 16'h0001;
      end else begin
        cnt_d = 16'(cnt_q - 16'h0001);
      end
    end
  end
  // counter register; holds while frozen since tick is low, unless a counter byte write clears it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q  <= 16'h0000;
      down_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      down_q <= down_d;
    end
  end
  // ==========================================================
  // channels
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    tce_channel u_ch (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tick     (tick),
      .center   (center_pwm_select_q),
      .mode     (ch_mode_q[i]),
      .els      (ch_els_q[i]),
      .value    (ch_val_q[i]),
      .count    (cnt_q),
      .pin      (ch_pin[i]),
      .event_p  (evt[i+1])
    );
    assign irq_en[i+1] = ch_ie_q[i];
  end
  assign irq_en[0] = overflow_irq_enable_q;
  // ==========================================================
  // two-step flag clear: read while set arms, write zero clears
  always_comb begin
    flag_d  = flag_q;
    armed_d = armed_q;
    for (int k = 0; k <= NCH; k++) begin
      if (flags_rd && flag_q[k]) armed_d[k] = 1'b1;
      if (flags_wr && armed_q[k] && !avs_writedata[k]) begin
        flag_d[k]  = 1'b0;                 // RQ4 RQ10
        armed_d[k] = 1'b0;
      end
      if (evt[k]) begin
        flag_d[k]  = 1'b1;                 // event wins, sequence resets
        armed_d[k] = 1'b0;                 // RQ10
      end
    end
  end
  // flag registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flag_q  <= '0;
      armed_q <= '0;
    end else begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
    end
  end
  // ==========================================================
  // sticky status, write one to clear, set wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sts_q <= '0;
    end else if (wr_acc && avs_address == tce_pkg::ADDR_STATUS) begin
      sts_q <= (sts_q & ~avs_writedata[NCH:0]) | evt;
    end else begin
      sts_q <= sts_q | evt;
    end
  end
  // level request: enabled flag or unmasked status
  assign irq = |(flag_q & irq_en) || |(sts_q & mask_q); // RQ12
  // ==========================================================
  // configuration writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ps_q                  <= 3'h0;
      center_pwm_select_q   <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
      mod_q                 <= tce_pkg::RST_MODULO;
      mask_q                <= '0;
      for (int k = 0; k < NCH; k++) begin
        ch_mode_q[k] <= tce_pkg::TCE_CAPTURE;
        ch_els_q[k]  <= tce_pkg::ELS_OFF;
        ch_ie_q[k]   <= 1'b0;
        ch_val_q[k]  <= 16'h0000;
      end
    end else if (wr_acc && avs_byteenable[0]) begin
      case (avs_address)
        tce_pkg::ADDR_CTRL: begin
          ps_q                  <= avs_writedata[tce_pkg::CTRL_PS_LSB +: 3];
          center_pwm_select_q   <= avs_writedata[tce_pkg::CTRL_CPWM_BIT];
          overflow_irq_enable_q <= avs_writedata[tce_pkg::CTRL_OVERFLOW_IRQ_ENABLE_BIT];
        end
        tce_pkg::ADDR_MASK: begin
          mask_q <= avs_writedata[NCH:0];
        end
        tce_pkg::ADDR_MODULO: begin
          mod_q <= avs_writedata[15:0];
        end
        default: begin
          if (ch_index(avs_address) >= 0) begin
            if (avs_address[2]) begin
              ch_val_q[ch_index(avs_address)] <= avs_writedata[15:0];
            end else begin
              ch_els_q[ch_index(avs_address)]  <= avs_writedata[tce_pkg::CH_ELS_LSB +: 2];
              ch_mode_q[ch_index(avs_address)] <= avs_writedata[tce_pkg::CH_MODE_LSB +: 2];
              ch_ie_q[ch_index(avs_address)]   <= avs_writedata[tce_pkg::CH_IE_BIT];
            end
          end
        end
      endcase
    end
  end
  // ==========================================================
  // read mux; counter bytes show the held count in debug
  always_comb begin
    rd_mux = tce_pkg::RD_UNMAPPED;
    case (avs_address)
      tce_pkg::ADDR_CTRL:   rd_mux = {27'h0, overflow_irq_enable_q, center_pwm_select_q, ps_q};
      tce_pkg::ADDR_STATUS: rd_mux = 32'(sts_q);
      tce_pkg::ADDR_MASK:   rd_mux = 32'(mask_q);
      tce_pkg::ADDR_CNT_HI: rd_mux = {24'h0, cnt_q[15:8]};  // RQ9
      tce_pkg::ADDR_CNT_LO: rd_mux = {24'h0, cnt_q[7:0]};   // RQ9
      tce_pkg::ADDR_MODULO: rd_mux = {16'h0, mod_q};
      tce_pkg::ADDR_FLAGS:  rd_mux = 32'(flag_q);
      default: begin
        if (ch_index(avs_address) >= 0) begin
          rd_mux = avs_address[2] ? {16'h0, ch_val_q[ch_index(avs_address)]} :
                   {27'h0, ch_ie_q[ch_index(avs_address)], ch_mode_q[ch_index(avs_address)],
                    ch_els_q[ch_index(avs_address)]};
        end
      end
    endcase
  end
  // answer timing and read data register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req && avs_read) rdata_q <= rd_mux;
    end
  end
  assign avs_readdata = rdata_q;
endmodule

/* tce_pkg.sv */
// Contract
// (RQ1) center pwm: overflow flag at up-to-down reversal
// (RQ2) capture edge select: off, rise, fall, both
// (RQ3) capture sets channel flag on selected edge
// (RQ4) channel flags clear only by two-step sequence
// (RQ5) output compare sets flag on counter match
// (RQ6) edge pwm sets flag at duty end match
// (RQ7) center pwm sets flag at both matches
// (RQ8) counter byte write clears counter and prescaler
// (RQ9) debug mode reads return frozen counter
// (RQ10) clear: read flag set, write zero; event wins
// (RQ11) up mode: overflow flag on wrap to zero
// (RQ12) enabled flags drive level interrupt request
// (RQ13) disabled edge select never sets capture flag
// (RQ14) counter ticks on prescaler enable pulse
package tce_pkg;
  // ==========================================================
  // register byte addresses (one 32-bit word each)
  localparam logic [5:0] ADDR_CTRL    = 6'h00; // prescale, center mode, overflow enable
  localparam logic [5:0] ADDR_STATUS  = 6'h04; // sticky flags, write one to clear
  localparam logic [5:0] ADDR_MASK    = 6'h08; // interrupt mask, same layout as status
  localparam logic [5:0] ADDR_CNT_HI  = 6'h0C; // counter high byte
  localparam logic [5:0] ADDR_CNT_LO  = 6'h10; // counter low byte
  localparam logic [5:0] ADDR_MODULO  = 6'h14; // modulus, zero means free run
  localparam logic [5:0] ADDR_FLAGS   = 6'h18; // two-step flag register
  localparam logic [5:0] ADDR_CH_BASE = 6'h20; // per channel: ctrl at +0, value at +4
  // ==========================================================
  // field positions
  localparam int CTRL_PS_LSB   = 0;  // prescale select, 3 bits
  localparam int CTRL_CPWM_BIT = 3;  // center_pwm_select
  localparam int CTRL_OVERFLOW_IRQ_ENABLE_BIT = 4;  // overflow_irq_enable
  localparam int CH_ELS_LSB    = 0;  // edge_select_lo at bit 0, edge_select_hi at bit 1
  localparam int CH_MODE_LSB   = 2;  // channel mode, 2 bits
  localparam int CH_IE_BIT     = 4;  // channel_irq_enable
  localparam logic [15:0] RST_MODULO = 16'h0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // ==========================================================
  // channel modes
  typedef enum logic [1:0] {
    TCE_CAPTURE = 2'b00,
    TCE_COMPARE = 2'b01,
    TCE_PWM     = 2'b10
  } tce_mode_t;
  // edge select codes
  localparam logic [1:0] ELS_OFF  = 2'b00;
  localparam logic [1:0] ELS_RISE = 2'b01;
  localparam logic [1:0] ELS_FALL = 2'b10;
  localparam logic [1:0] ELS_BOTH = 2'b11;
endpackage

/* tce_prescaler.sv */
`timescale 1ns/1ps
// ==========================================================
// divider: one-cycle tick every 2^sel bus clocks
module tce_prescaler (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clear,    // restart divide chain
  input  wire logic       freeze,   // hold during debug
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [6:0] div_q;             // free divide chain
  logic [6:0] div_d;
  logic [6:0] mask;              // low bits that must be all ones
  assign mask  = 7'((8'h01 << sel) - 8'h01);
  assign tick  = !freeze && ((div_q & mask) == mask);
  assign div_d = clear ? 7'h00 : (freeze ? div_q : 7'(div_q + 7'h01));
  // divide register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_d;
    end
  end
endmodule

/* tce_channel.sv */
`timescale 1ns/1ps
// ==========================================================
// one channel: pin edge detect every clock, compare match detect per counter tick
module tce_channel (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        center,     // counter in up/down mode
  input  wire logic [1:0]  mode,
  input  wire logic [1:0]  els,
  input  wire logic [15:0] value,
  input  wire logic [15:0] count,
  input  wire logic        pin,
  output logic             event_p     // one-cycle event pulse
);
  logic pin_q;                        // previous pin level
  logic rise;
  logic fall;
  logic edge_hit;
  logic match;
  assign rise  = pin && !pin_q;
  assign fall  = !pin && pin_q;
  // off selects nothing, so pin activity is ignored
  assign edge_hit = ((els == tce_pkg::ELS_RISE) && rise) ||      // RQ2 RQ13
                    ((els == tce_pkg::ELS_FALL) && fall) ||
                    ((els == tce_pkg::ELS_BOTH) && (rise || fall));
  // in center mode each value strictly between zero and the top is met going up and going down
  assign match = tick && (count == value);                       // RQ5 RQ6 RQ7
  assign event_p = (mode == tce_pkg::TCE_CAPTURE) ? edge_hit :   // RQ3
                   (mode == tce_pkg::TCE_COMPARE || mode == tce_pkg::TCE_PWM) ? match : 1'b0;
  // pin history register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
    end
  end
endmodule

/* tce_top_assertions.sv */
`timescale 1ns/1ps
// ==========================================================
// port checks for the timer block
module tce_top_checker #(
  parameter int NCH = 2
) (
  input wire logic           core_clk,
  input wire logic           rst_n,
  input wire logic [5:0]     avs_address,
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic [31:0]    avs_writedata,
  input wire logic [3:0]     avs_byteenable,
  input wire logic [31:0]    avs_readdata,
  input wire logic           avs_waitrequest,
  input wire logic           background_debug_mode,
  input wire logic [NCH-1:0] ch_pin,
  input wire logic           irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic req = avs_read | avs_write;         // any request
  wire logic ans = avs_read & ~avs_waitrequest;  // read answered
  wire logic cnt = (avs_address == tce_pkg::ADDR_CNT_LO) | (avs_address == tce_pkg::ADDR_CNT_HI);
  logic [31:0] frz_q;                            // frozen counter word
  logic        frz_v_q;                          // frz_q is trusted
  // ==========================================================
  // frozen count; trusted only two cycles into debug, as freeze may lag
  always_ff @(posedge core_clk) begin
    if (!rst_n || !background_debug_mode || !$past(background_debug_mode, 2)) begin
      frz_v_q <= 1'b0;
    end else if (avs_write && !avs_waitrequest && cnt) begin
      frz_v_q <= 1'b1;  // write zeroes the counter
      frz_q   <= 32'h0;
    end else if (ans && avs_address == tce_pkg::ADDR_CNT_LO && !frz_v_q) begin
      frz_v_q <= 1'b1;
      frz_q   <= avs_readdata;
    end
  end
  // ==========================================================
  // assertions
  property p_wait_first; $rose(req) |-> avs_waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("new request not held off");
  property p_wait_two; req && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_two: assert property (p_wait_two) else $error("request not answered in one cycle");
  property p_idle; !req |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait state while idle");
  property p_stands; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
  a_stands: assert property (p_stands) else $error("read data moved between answers");
  property p_gap; ans && avs_address == 6'h1C |-> avs_readdata == tce_pkg::RD_UNMAPPED; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read not zero");
  property p_no_ch; ans && int'(avs_address) >= 32 + 8 * NCH |-> avs_readdata == 32'h0; endproperty
  a_no_ch: assert property (p_no_ch) else $error("missing channel read not zero");
  property p_irq_rst; !$past(rst_n) |-> !irq; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
  property p_frozen; ans && avs_address == tce_pkg::ADDR_CNT_LO && frz_v_q |-> avs_readdata == frz_q; endproperty
  a_frozen: assert property (p_frozen) else $error("counter moved in debug");
  c_cap: cover property (ans && avs_address == tce_pkg::ADDR_STATUS && avs_readdata[2]);
  c_irq: cover property ($rose(irq));
  c_frz: cover property (ans && frz_v_q);
endmodule

bind tce_top tce_top_checker #(.NCH(NCH)) tce_top_checker_i (.core_clk(core_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .background_debug_mode(background_debug_mode), .ch_pin(ch_pin), .irq(irq));

/* testbench.sv */
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the timer event flags
module testbench;
  logic        core_clk;
  logic        rst_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        background_debug_mode;
  logic [1:0]  ch_pin;
  logic        irq;
  logic [31:0] rq;         // last word read
  int          fails;
  int          tests_run;
  int          cyc;        // cycles since start

  tce_top #(.NCH(2)) tce_top_i (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .background_debug_mode(background_debug_mode), .ch_pin(ch_pin), .irq(irq));

  always #5 core_clk = ~core_clk;
  // hang guard; the run needs well under two thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      finish_test();
    end
  end
  // ==========================================================
  // bus access; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rq = avs_readdata;      // value standing at the answering edge
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge core_clk);    // one idle edge before the next request
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run = tests_run + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rq, e);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rdc(tce_pkg::ADDR_CTRL, 32'h0);
    rdc(tce_pkg::ADDR_STATUS, 32'h0);
    rdc(tce_pkg::ADDR_MODULO, {16'h0, tce_pkg::RST_MODULO});
    rdc(tce_pkg::ADDR_FLAGS, 32'h0);
    wr(6'h1C, 32'hFFFFFFFF);  // gap: write ignored
    rdc(6'h1C, tce_pkg::RD_UNMAPPED);
    rdc(6'h30, 32'h0);        // channel 2 absent
    $display("t_regs done");
  endtask
  task automatic t_compare();
    wr(tce_pkg::ADDR_CNT_LO, 32'h0);
    wr(tce_pkg::ADDR_CH_BASE + 6'h04, 32'h40);
    wr(tce_pkg::ADDR_CH_BASE, 32'h14);  // compare, irq enabled
    wr(tce_pkg::ADDR_MASK, 32'h2);
    rdc(tce_pkg::ADDR_STATUS, 32'h0);
    repeat (80) @(posedge core_clk);
    rdc(tce_pkg::ADDR_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(tce_pkg::ADDR_MASK, 32'h0);
    chk({31'h0, irq}, 32'h1);
    wr(tce_pkg::ADDR_FLAGS, 32'h0);     // zero without a prior read
    rdc(tce_pkg::ADDR_FLAGS, 32'h2);
    wr(tce_pkg::ADDR_FLAGS, 32'h0);
    rdc(tce_pkg::ADDR_FLAGS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(tce_pkg::ADDR_STATUS, 32'h2);
    wr(tce_pkg::ADDR_MASK, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(tce_pkg::ADDR_CH_BASE, 32'h0);
    $display("t_compare done");
  endtask
  task automatic t_capture();
    logic [1:0] e;
    for (int i = 0; i < 4; i++) begin
      e = 2'(i);
      wr(tce_pkg::ADDR_CH_BASE + 6'h08, {30'h0, e});  // channel 1 capture
      wr(tce_pkg::ADDR_STATUS, 32'h7);
      ch_pin <= 2'h3;  // channel 0 stays off
      repeat (4) @(posedge core_clk);
      rdc(tce_pkg::ADDR_STATUS, {29'h0, e[0], 2'h0});
      wr(tce_pkg::ADDR_STATUS, 32'h7);
      ch_pin <= 2'h0;
      repeat (4) @(posedge core_clk);
      rdc(tce_pkg::ADDR_STATUS, {29'h0, e[1], 2'h0});
    end
    $display("t_capture done");
  endtask
  task automatic t_debug();
    logic [31:0] v;
    background_debug_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    bus(1'b0, tce_pkg::ADDR_CNT_LO, 32'h0);
    v = rq;
    repeat (8) @(posedge core_clk);
    rdc(tce_pkg::ADDR_CNT_LO, v);
    wr(tce_pkg::ADDR_CNT_HI, 32'hFF);
    rdc(tce_pkg::ADDR_CNT_LO, 32'h0);
    background_debug_mode <= 1'b0;
    $display("t_debug done");
  endtask
  task automatic t_overflow();
    wr(tce_pkg::ADDR_MODULO, 32'h10);
    wr(tce_pkg::ADDR_CH_BASE + 6'h04, 32'h5);
    wr(tce_pkg::ADDR_CH_BASE, 32'h08);  // edge pwm
    wr(tce_pkg::ADDR_CTRL, 32'h3);      // tick every 8 clocks
    wr(tce_pkg::ADDR_CNT_LO, 32'h0);
    wr(tce_pkg::ADDR_STATUS, 32'h7);
    repeat (100) @(posedge core_clk);
    rdc(tce_pkg::ADDR_STATUS, 32'h2);
    repeat (100) @(posedge core_clk);
    rdc(tce_pkg::ADDR_STATUS, 32'h3);
    $display("t_overflow done");
  endtask
  task automatic t_center();
    wr(tce_pkg::ADDR_CTRL, 32'h8);      // up/down, tick every clock
    wr(tce_pkg::ADDR_MODULO, 32'h20);
    wr(tce_pkg::ADDR_CH_BASE + 6'h04, 32'h8);
    wr(tce_pkg::ADDR_CNT_LO, 32'h0);
    wr(tce_pkg::ADDR_STATUS, 32'h7);
    repeat (6) @(posedge core_clk);
    rdc(tce_pkg::ADDR_STATUS, 32'h2);
    wr(tce_pkg::ADDR_STATUS, 32'h7);
    repeat (44) @(posedge core_clk);
    rdc(tce_pkg::ADDR_STATUS, 32'h3);
    $display("t_center done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    background_debug_mode = 1'b0;
    ch_pin = 2'h0;
    fails = 0;
    tests_run = 0;
    cyc = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_compare();
    t_capture();
    t_debug();
    t_overflow();
    t_center();
    finish_test();
  end
endmodule
